/* File: sdrpi_defines.vh */
`ifndef SDRPI_DEFINES_VH
`define SDRPI_DEFINES_VH

// ----------------------------------------
// Command codes on {ras_n, cas_n, we_n}
// ----------------------------------------
`define SDRPI_CMD_MRS 3'h0
`define SDRPI_CMD_REF 3'h1
`define SDRPI_CMD_PRE 3'h2
`define SDRPI_CMD_ACT 3'h3
`define SDRPI_CMD_WR 3'h4
`define SDRPI_CMD_RD 3'h5
`define SDRPI_CMD_BST 3'h6
`define SDRPI_CMD_NOP 3'h7

// ----------------------------------------
// Widths and field positions
// ----------------------------------------
`define SDRPI_ADDR_W 13
`define SDRPI_COL_W 10
`define SDRPI_LANES 8
`define SDRPI_DATA_W 64
`define SDRPI_AP_BIT 10
`define SDRPI_BL_MSB 2
`define SDRPI_BL_LSB 0
`define SDRPI_PWR_W 5

// ----------------------------------------
// Reset values, counts and device address
// ----------------------------------------
`define SDRPI_MODE_RST 13'h0000
`define SDRPI_FULL_PAGE 11'h400
`define SDRPI_SPD_DEV 7'h50

`endif

/* File: sdrpi_rank.v */
`timescale 1ns/1ns
`include "sdrpi_defines.vh"

module sdrpi_rank (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Pins of this rank, all captured except cke_pin_in, and burst length
  input wire cke_pin_in,
  input wire cke_ff_in,
  input wire sel_in,
  input wire [2:0] cmd_in,
  input wire [1:0] bank_in,
  input wire ap_in,
  input wire [10:0] blen_in,
  // State
  output wire run_out,
  output wire [4:0] pwr_out,
  output wire [3:0] open_out,
  output wire burst_out,
  output wire burst_wr_out
);

  // ----------------------------------------
  // Power states
  // ----------------------------------------
  localparam [4:0] ST_RUN = 5'h01;
  localparam [4:0] ST_SUSP = 5'h02;
  localparam [4:0] ST_PPD = 5'h04;
  localparam [4:0] ST_APD = 5'h08;
  localparam [4:0] ST_SREF = 5'h10;

  reg [4:0] st_ff;
  reg [4:0] nxt_st;
  reg [3:0] open_ff;
  reg [3:0] nxt_open;
  reg [10:0] rem_ff;
  reg [10:0] nxt_rem;
  reg ap_ff;
  reg nxt_ap;
  reg [1:0] apb_ff;
  reg [1:0] nxt_apb;
  reg wr_ff;
  reg nxt_wr;
  wire take;

  assign take = sel_in & cke_ff_in & st_ff[0];
  assign run_out = st_ff[0];
  assign pwr_out = st_ff;
  assign open_out = open_ff;
  assign burst_out = (rem_ff != 11'h000);
  assign burst_wr_out = wr_ff;

  always @* begin
    nxt_st = st_ff;
    nxt_open = open_ff;
    nxt_rem = rem_ff;
    nxt_ap = ap_ff;
    nxt_apb = apb_ff;
    nxt_wr = wr_ff;
    case (st_ff)
      // entry by burst state, refresh command and bank state
      ST_RUN: begin
        if (!cke_ff_in) begin
          if (rem_ff != 11'h000)
            nxt_st = ST_SUSP;
          else if (sel_in && cmd_in == `SDRPI_CMD_REF)
            nxt_st = ST_SREF;
          else if (|open_ff)
            nxt_st = ST_APD;
          else
            nxt_st = ST_PPD;
        end
      end
      ST_SUSP: begin
        if (cke_ff_in)
          nxt_st = ST_RUN;
      end
      ST_PPD, ST_APD, ST_SREF: begin
        if (cke_pin_in)
          nxt_st = ST_RUN;
      end
      default: nxt_st = ST_RUN;
    endcase
    if (st_ff[0] && cke_ff_in && rem_ff != 11'h000) begin
      nxt_rem = rem_ff - 11'h001;
      if (rem_ff == 11'h001 && ap_ff)
        nxt_open[apb_ff] = 1'b0;
    end
    if (take) begin
      case (cmd_in)
        `SDRPI_CMD_ACT: nxt_open[bank_in] = 1'b1;
        `SDRPI_CMD_RD, `SDRPI_CMD_WR: begin
          nxt_rem = blen_in - 11'h001;
          nxt_wr = (cmd_in == `SDRPI_CMD_WR);
          nxt_ap = ap_in;
          nxt_apb = bank_in;
          if (blen_in == 11'h001 && ap_in)
            nxt_open[bank_in] = 1'b0;
        end
        `SDRPI_CMD_BST: nxt_rem = 11'h000;
        `SDRPI_CMD_PRE: begin
          if (ap_in)
            nxt_open = 4'h0;
          else
            nxt_open[bank_in] = 1'b0;
        end
        default: nxt_rem = nxt_rem;
      endcase
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= ST_RUN;
      open_ff <= 4'h0;
      rem_ff <= 11'h000;
      ap_ff <= 1'b0;
      apb_ff <= 2'h0;
      wr_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      open_ff <= nxt_open;
      rem_ff <= nxt_rem;
      ap_ff <= nxt_ap;
      apb_ff <= nxt_apb;
      wr_ff <= nxt_wr;
    end
  end

endmodule // sdrpi_rank

/* File: sdrpi_pin_if.v */
`timescale 1ns/1ns
`include "sdrpi_defines.vh"

module sdrpi_pin_if (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Command pins
  input wire rank0_select_n_in,
  input wire rank1_select_n_in,
  input wire ras_n_in,
  input wire cas_n_in,
  input wire we_n_in,
  input wire cke0_in,
  input wire cke1_in,
  input wire bank_sel0_in,
  input wire bank_sel1_in,
  input wire [12:0] addr_in,
  // Data pins
  input wire [7:0] byte_lane_mask_in,
  input wire [63:0] data_bus_in,
  output wire [63:0] data_bus_out,
  output wire [7:0] data_bus_oe_out,
  // Presence detect
  input wire spd_scl_in,
  input wire spd_sda_in,
  output wire spd_sda_out,
  output wire spd_sda_oe_out,
  // Array side
  output wire cmd_stb_out,
  output wire [2:0] cmd_code_out,
  output wire cmd_rank_out,
  output wire [1:0] cmd_bank_out,
  output wire [12:0] cmd_addr_out,
  output wire cmd_ap_out,
  output wire [12:0] mode_op_out,
  output wire [7:0] beat_wr_out,
  output wire beat_rd_out,
  output wire beat_rank_out,
  output wire [1:0] beat_bank_out,
  output wire [9:0] beat_col_out,
  output wire [63:0] beat_data_out,
  input wire [63:0] rd_data_in,
  // Status
  output wire [7:0] bank_open_out,
  output wire [4:0] pwr_state0_out,
  output wire [4:0] pwr_state1_out,
  output wire [1:0] in_buf_en_out
);

  // ----------------------------------------
  // Pin capture
  // ----------------------------------------
  reg [1:0] cs_n_ff;
  reg [2:0] cmd_ff;
  reg [1:0] cke_ff;
  reg [1:0] bank_ff;
  reg [12:0] addr_ff;
  reg [7:0] mask_ff;
  reg [7:0] mask_d1_ff;
  reg [63:0] wdata_ff;
  reg [12:0] mode_ff;
  wire run0, run1, bst0, bst1, bwr0, bwr1;
  wire [3:0] open0, open1;
  wire [4:0] pwr0, pwr1;
  wire [1:0] buf_en;

  assign buf_en = {pwr1[0] | pwr1[1], pwr0[0] | pwr0[1]};

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cs_n_ff <= 2'h3;
      cmd_ff <= `SDRPI_CMD_NOP;
      // Live enable out of reset, else a false power-down follows release
      cke_ff <= 2'h3;
      bank_ff <= 2'h0;
      addr_ff <= 13'h0000;
      mask_ff <= 8'h00;
      mask_d1_ff <= 8'h00;
      wdata_ff <= 64'h0;
    end else begin
      cs_n_ff[0] <= buf_en[0] ? rank0_select_n_in : 1'b1;
      cs_n_ff[1] <= buf_en[1] ? rank1_select_n_in : 1'b1;
      cmd_ff <= {ras_n_in, cas_n_in, we_n_in};
      cke_ff <= {cke1_in, cke0_in};
      bank_ff <= {bank_sel1_in, bank_sel0_in};
      addr_ff <= addr_in;
      mask_ff <= byte_lane_mask_in;
      mask_d1_ff <= mask_ff;
      wdata_ff <= data_bus_in;
    end
  end

  // ----------------------------------------
  // Rank trackers
  // ----------------------------------------
  reg [10:0] blen;

  always @* begin
    case (mode_ff[`SDRPI_BL_MSB:`SDRPI_BL_LSB])
      3'h0: blen = 11'h001;
      3'h1: blen = 11'h002;
      3'h2: blen = 11'h004;
      3'h3: blen = 11'h008;
      3'h7: blen = `SDRPI_FULL_PAGE;
      default: blen = 11'h001;
    endcase
  end

  sdrpi_rank u_rank0 (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .cke_pin_in(cke0_in),
    .cke_ff_in(cke_ff[0]),
    .sel_in(~cs_n_ff[0]),
    .cmd_in(cmd_ff),
    .bank_in(bank_ff),
    .ap_in(addr_ff[`SDRPI_AP_BIT]),
    .blen_in(blen),
    .run_out(run0),
    .pwr_out(pwr0),
    .open_out(open0),
    .burst_out(bst0),
    .burst_wr_out(bwr0)
  );

  sdrpi_rank u_rank1 (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .cke_pin_in(cke1_in),
    .cke_ff_in(cke_ff[1]),
    .sel_in(~cs_n_ff[1]),
    .cmd_in(cmd_ff),
    .bank_in(bank_ff),
    .ap_in(addr_ff[`SDRPI_AP_BIT]),
    .blen_in(blen),
    .run_out(run1),
    .pwr_out(pwr1),
    .open_out(open1),
    .burst_out(bst1),
    .burst_wr_out(bwr1)
  );

  // ----------------------------------------
  // Command decode and beats
  // ----------------------------------------
  wire take0, take1, take_any, is_rw, cont, beat, beat_wr;
  reg [9:0] col_ff;
  reg brank_ff;
  reg [1:0] bbank_ff;

  // edge counts only with enable high
  assign take0 = ~cs_n_ff[0] & cke_ff[0] & run0;
  assign take1 = ~cs_n_ff[1] & cke_ff[1] & run1;
  assign take_any = take0 | take1;
  assign is_rw = take_any & (cmd_ff == `SDRPI_CMD_RD | cmd_ff == `SDRPI_CMD_WR);
  assign cont = (bst0 & run0 & cke_ff[0]) | (bst1 & run1 & cke_ff[1]);
  assign beat = is_rw | cont;
  assign beat_wr = is_rw ? (cmd_ff == `SDRPI_CMD_WR) : (bst0 ? bwr0 : bwr1);

  reg cmd_stb_ff;
  reg [2:0] cmd_code_ff;
  reg cmd_rank_ff;
  reg [1:0] cmd_bank_ff;
  reg [12:0] cmd_addr_ff;
  reg cmd_ap_ff;
  reg [7:0] beat_wr_ff;
  reg beat_rd_ff;
  reg beat_rank_ff;
  reg [1:0] beat_bank_ff;
  reg [9:0] beat_col_ff;
  reg [63:0] beat_data_ff;
  reg [63:0] dq_out_ff;
  reg [7:0] dq_oe_ff;
  reg [7:0] open_all_ff;
  reg [4:0] pwr0_ff, pwr1_ff;
  reg [1:0] buf_en_ff;
  wire [9:0] cur_col;

  assign cur_col = is_rw ? addr_ff[`SDRPI_COL_W-1:0] : col_ff;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_ff <= `SDRPI_MODE_RST;
      cmd_stb_ff <= 1'b0;
      cmd_code_ff <= `SDRPI_CMD_NOP;
      cmd_rank_ff <= 1'b0;
      cmd_bank_ff <= 2'h0;
      cmd_addr_ff <= 13'h0000;
      cmd_ap_ff <= 1'b0;
      col_ff <= 10'h000;
      brank_ff <= 1'b0;
      bbank_ff <= 2'h0;
      beat_wr_ff <= 8'h00;
      beat_rd_ff <= 1'b0;
      beat_rank_ff <= 1'b0;
      beat_bank_ff <= 2'h0;
      beat_col_ff <= 10'h000;
      beat_data_ff <= 64'h0;
      dq_out_ff <= 64'h0;
      dq_oe_ff <= 8'h00;
      open_all_ff <= 8'h00;
      pwr0_ff <= 5'h01;
      pwr1_ff <= 5'h01;
      buf_en_ff <= 2'h3;
    end else begin
      cmd_stb_ff <= take_any & (cmd_ff != `SDRPI_CMD_NOP);
      cmd_code_ff <= cmd_ff;
      cmd_rank_ff <= ~take0;
      cmd_bank_ff <= bank_ff;
      cmd_addr_ff <= addr_ff;
      cmd_ap_ff <= addr_ff[`SDRPI_AP_BIT];
      if (take_any && cmd_ff == `SDRPI_CMD_MRS)
        mode_ff <= addr_ff;
      if (is_rw) begin
        brank_ff <= ~take0;
        bbank_ff <= bank_ff;
      end
      if (beat)
        col_ff <= cur_col + 10'h001;
      beat_wr_ff <= (beat && beat_wr) ? ~mask_ff : 8'h00;
      beat_rd_ff <= beat & ~beat_wr;
      beat_rank_ff <= is_rw ? ~take0 : brank_ff;
      beat_bank_ff <= is_rw ? bank_ff : bbank_ff;
      beat_col_ff <= cur_col;
      beat_data_ff <= wdata_ff;
      dq_out_ff <= rd_data_in;
      // lane floats two clocks after mask
      dq_oe_ff <= beat_rd_ff ? ~mask_d1_ff : 8'h00;
      open_all_ff <= {open1, open0};
      pwr0_ff <= pwr0;
      pwr1_ff <= pwr1;
      buf_en_ff <= buf_en;
    end
  end

  // ----------------------------------------
  // Presence-detect serial slave
  // ----------------------------------------
  localparam [4:0] I_IDLE = 5'h01;
  localparam [4:0] I_RECV = 5'h02;
  localparam [4:0] I_ACK = 5'h04;
  localparam [4:0] I_SEND = 5'h08;
  localparam [4:0] I_RACK = 5'h10;

  reg [2:0] scl_sync_ff, sda_sync_ff;
  reg scl_f_ff, sda_f_ff;
  reg [4:0] i_st_ff;
  reg [7:0] sh_ff;
  reg [3:0] cnt_ff;
  reg [1:0] nbyte_ff;
  reg rw_ff;
  reg [7:0] ptr_ff;
  reg oe_ff;
  reg [7:0] spd_mem [0:255];
  wire scl_n, sda_n, scl_rise, scl_fall, start, stop;

  // Filtered value moves only when stages two and three agree
  assign scl_n = (scl_sync_ff[1] == scl_sync_ff[2]) ? scl_sync_ff[2] : scl_f_ff;
  assign sda_n = (sda_sync_ff[1] == sda_sync_ff[2]) ? sda_sync_ff[2] : sda_f_ff;
  assign scl_rise = scl_n & ~scl_f_ff;
  assign scl_fall = ~scl_n & scl_f_ff;
  assign start = scl_n & scl_f_ff & sda_f_ff & ~sda_n;
  assign stop = scl_n & scl_f_ff & ~sda_f_ff & sda_n;

  // Storage has no reset; host writes before trusting reads
  always @(posedge clk_in) begin
    if (scl_fall && i_st_ff == I_RECV && cnt_ff == 4'h8 && nbyte_ff == 2'h2 && !rw_ff)
      spd_mem[ptr_ff] <= sh_ff;
  end

  // two-way data line on host clock
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
      scl_f_ff <= 1'b1;
      sda_f_ff <= 1'b1;
      i_st_ff <= I_IDLE;
      sh_ff <= 8'h00;
      cnt_ff <= 4'h0;
      nbyte_ff <= 2'h0;
      rw_ff <= 1'b0;
      ptr_ff <= 8'h00;
      oe_ff <= 1'b0;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], spd_scl_in};
      sda_sync_ff <= {sda_sync_ff[1:0], spd_sda_in};
      scl_f_ff <= scl_n;
      sda_f_ff <= sda_n;
      if (start) begin
        i_st_ff <= I_RECV;
        cnt_ff <= 4'h0;
        nbyte_ff <= 2'h0;
        oe_ff <= 1'b0;
      end else if (stop) begin
        i_st_ff <= I_IDLE;
        oe_ff <= 1'b0;
      end else if (scl_rise) begin
        if (i_st_ff == I_RECV && cnt_ff != 4'h8) begin
          sh_ff <= {sh_ff[6:0], sda_n};
          cnt_ff <= cnt_ff + 4'h1;
        end
        // Host not acknowledging ends the read
        if (i_st_ff == I_RACK && sda_n)
          i_st_ff <= I_IDLE;
      end else if (scl_fall) begin
        case (i_st_ff)
          I_RECV: begin
            if (cnt_ff == 4'h8) begin
              cnt_ff <= 4'h0;
              if (nbyte_ff == 2'h0 && sh_ff[7:1] != `SDRPI_SPD_DEV) begin
                i_st_ff <= I_IDLE;
              end else begin
                oe_ff <= 1'b1;
                i_st_ff <= I_ACK;
                if (nbyte_ff == 2'h0)
                  rw_ff <= sh_ff[0];
                else if (nbyte_ff == 2'h1)
                  ptr_ff <= sh_ff;
                else
                  ptr_ff <= ptr_ff + 8'h01;
                if (nbyte_ff != 2'h2)
                  nbyte_ff <= nbyte_ff + 2'h1;
              end
            end
          end
          I_ACK, I_RACK: begin
            if (rw_ff) begin
              sh_ff <= spd_mem[ptr_ff];
              oe_ff <= ~spd_mem[ptr_ff][7];
              cnt_ff <= 4'h1;
              i_st_ff <= I_SEND;
            end else begin
              oe_ff <= 1'b0;
              i_st_ff <= I_RECV;
            end
          end
          I_SEND: begin
            if (cnt_ff == 4'h8) begin
              oe_ff <= 1'b0;
              ptr_ff <= ptr_ff + 8'h01;
              i_st_ff <= I_RACK;
            end else begin
              oe_ff <= ~sh_ff[6];
              sh_ff <= {sh_ff[6:0], 1'b0};
              cnt_ff <= cnt_ff + 4'h1;
            end
          end
          default: i_st_ff <= I_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign data_bus_out = dq_out_ff;
  assign data_bus_oe_out = dq_oe_ff;
  assign spd_sda_out = 1'b0;
  assign spd_sda_oe_out = oe_ff;
  assign cmd_stb_out = cmd_stb_ff;
  assign cmd_code_out = cmd_code_ff;
  assign cmd_rank_out = cmd_rank_ff;
  assign cmd_bank_out = cmd_bank_ff;
  assign cmd_addr_out = cmd_addr_ff;
  assign cmd_ap_out = cmd_ap_ff;
  assign mode_op_out = mode_ff;
  assign beat_wr_out = beat_wr_ff;
  assign beat_rd_out = beat_rd_ff;
  assign beat_rank_out = beat_rank_ff;
  assign beat_bank_out = beat_bank_ff;
  assign beat_col_out = beat_col_ff;
  assign beat_data_out = beat_data_ff;
  assign bank_open_out = open_all_ff;
  assign pwr_state0_out = pwr0_ff;
  assign pwr_state1_out = pwr1_ff;
  assign in_buf_en_out = buf_en_ff;

endmodule // sdrpi_pin_if

/* File: sdrpi_host.sv */
`timescale 1ns/1ns
`include "sdrpi_defines.vh"

module sdrpi_host (
  // Clock
  input wire clk_in,
  // Command pins
  output reg rank0_select_n_out,
  output reg rank1_select_n_out,
  output reg [2:0] cmd_n_out,
  output reg [1:0] cke_out,
  output reg [1:0] bank_out,
  output reg [12:0] addr_out,
  // Write data pins
  output reg [7:0] mask_out,
  output reg [63:0] data_out
);
  // ----------------------------------------
  // Controller side of the pins
  // ----------------------------------------
  initial begin
    {rank1_select_n_out, rank0_select_n_out, cmd_n_out, cke_out} = 7'h7f;
    {bank_out, addr_out, mask_out, data_out} = 87'h0;
  end
  // Lanes change between edges only
  task lanes(input [7:0] m, input [63:0] d);
    begin
      mask_out = m;
      data_out = d;
    end
  endtask
  // Clock enables hold until changed
  task clk_en(input [1:0] ck);
    begin
      cke_out = ck;
    end
  endtask
  task issue(input [2:0] code, input [1:0] sel, input [1:0] ck, input [1:0] bank, input [12:0] addr);
    begin
      @(negedge clk_in);
      {rank1_select_n_out, rank0_select_n_out} = sel;
      cmd_n_out = code;
      cke_out = ck;
      bank_out = bank;
      addr_out = addr;
      @(negedge clk_in);
      // Stale bank and address inverted, never a lucky match
      {rank1_select_n_out, rank0_select_n_out} = 2'h3;
      cmd_n_out = `SDRPI_CMD_NOP;
      bank_out = ~bank;
      addr_out = ~addr;
    end
  endtask
endmodule // sdrpi_host

/* File: sdrpi_chk_assertions.sv */
`timescale 1ns/1ns

module sdrpi_chk (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Command pins
  input wire rank0_select_n_in,
  input wire rank1_select_n_in,
  input wire ras_n_in,
  input wire cas_n_in,
  input wire we_n_in,
  input wire cke0_in,
  input wire cke1_in,
  input wire [7:0] byte_lane_mask_in,
  // Outputs watched
  input wire [7:0] data_bus_oe_out,
  input wire cmd_stb_out,
  input wire [2:0] cmd_code_out,
  input wire cmd_rank_out,
  input wire [1:0] cmd_bank_out,
  input wire [12:0] cmd_addr_out,
  input wire cmd_ap_out,
  input wire [12:0] mode_op_out,
  input wire [7:0] beat_wr_out,
  input wire beat_rd_out,
  input wire [7:0] bank_open_out,
  input wire [4:0] pwr_state0_out,
  input wire [1:0] in_buf_en_out
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  wire [2:0] pin_cmd = {ras_n_in, cas_n_in, we_n_in};
  wire [3:0] hit = 4'h1 << cmd_bank_out;
  wire take0 = !rank0_select_n_in && cke0_in && pwr_state0_out == 5'h01 && pin_cmd != 3'h7;
  wire pre0 = cmd_stb_out && !cmd_rank_out && cmd_code_out == 3'h2;
  wire act0 = cmd_stb_out && !cmd_rank_out && cmd_code_out == 3'h3;
  wire low0 = (pwr_state0_out & 5'h1c) != 5'h00;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_cmd_strobe: assert property (take0 |-> ##2 cmd_stb_out && cmd_code_out == $past(pin_cmd, 2))
    else $error("command strobe missing");
  chk_deselect_quiet: assert property (rank0_select_n_in && rank1_select_n_in |-> ##2 !cmd_stb_out)
    else $error("deselected command strobed");
  chk_bank_opens: assert property (act0 |=> (bank_open_out[3:0] & $past(hit)) == $past(hit))
    else $error("bank not opened");
  chk_precharge_close: assert property (pre0 |=> (bank_open_out[3:0] & ($past(cmd_ap_out) ? 4'hf : $past(hit))) == 4'h0)
    else $error("bank not closed");
  chk_mode_load: assert property (cmd_stb_out && cmd_code_out == 3'h0 |-> mode_op_out == cmd_addr_out)
    else $error("mode code not loaded");
  chk_write_mask: assert property (beat_wr_out != 8'h00 |-> beat_wr_out == ~$past(byte_lane_mask_in, 2))
    else $error("write lanes disagree with mask");
  chk_read_float: assert property (beat_rd_out |=> data_bus_oe_out == ~$past(byte_lane_mask_in, 3))
    else $error("read drive disagrees with mask");
  chk_suspend_hold: assert property (!cke0_in && !cke1_in |-> ##2 beat_wr_out == 8'h00 && !beat_rd_out)
    else $error("beat while clock stopped");
  // State output lags the tracker by one edge
  chk_pd_exit: assert property (low0 && cke0_in |-> ##2 pwr_state0_out == 5'h01)
    else $error("no exit on enable");
  // Entry edge skipped, buffer flag registers on the same edge as the state output
  chk_buffers_off: assert property (low0 && $stable(pwr_state0_out) |-> !in_buf_en_out[0])
    else $error("buffers on in low power");
endmodule // sdrpi_chk

bind sdrpi_pin_if sdrpi_chk u_sdrpi_chk (.*);

/* File: tb_sdrpi_pin_if.sv */
`timescale 1ns/1ns
`include "sdrpi_defines.vh"

module tb_sdrpi_pin_if;
  reg clk_in;
  reg rst_n_in;
  reg [63:0] rd_data;
  reg prev;
  integer err_total;
  integer comparisons;
  integer i;
  integer n;
  reg scl;
  reg sda_drv;
  reg [7:0] spd_byte;
  wire sda_o;
  wire sda_line;
  wire r0_n, r1_n, cmd_stb, cmd_rank, cmd_ap, beat_rd, beat_rank, sda_oe;
  wire [1:0] cke, ba, cmd_bank, buf_en, beat_bank;
  wire [2:0] cmd_n, cmd_code;
  wire [4:0] pwr0, pwr1;
  wire [7:0] mask, oe, beat_wr, bank_open;
  wire [9:0] beat_col;
  wire [12:0] addr, cmd_addr, mode_op;
  wire [63:0] wdata, data_out, beat_data;
  sdrpi_host u_sdrpi_host (.clk_in(clk_in), .rank0_select_n_out(r0_n), .rank1_select_n_out(r1_n),
    .cmd_n_out(cmd_n), .cke_out(cke), .bank_out(ba), .addr_out(addr), .mask_out(mask), .data_out(wdata));
  sdrpi_pin_if u_sdrpi_pin_if (.clk_in(clk_in), .rst_n_in(rst_n_in), .rank0_select_n_in(r0_n),
    .rank1_select_n_in(r1_n), .ras_n_in(cmd_n[2]), .cas_n_in(cmd_n[1]), .we_n_in(cmd_n[0]),
    .cke0_in(cke[0]), .cke1_in(cke[1]), .bank_sel0_in(ba[0]), .bank_sel1_in(ba[1]), .addr_in(addr),
    .byte_lane_mask_in(mask), .data_bus_in(wdata), .data_bus_out(data_out), .data_bus_oe_out(oe),
    .spd_scl_in(scl), .spd_sda_in(sda_line), .spd_sda_out(sda_o), .spd_sda_oe_out(sda_oe),
    .cmd_stb_out(cmd_stb), .cmd_code_out(cmd_code), .cmd_rank_out(cmd_rank), .cmd_bank_out(cmd_bank),
    .cmd_addr_out(cmd_addr), .cmd_ap_out(cmd_ap), .mode_op_out(mode_op), .beat_wr_out(beat_wr),
    .beat_rd_out(beat_rd), .beat_rank_out(beat_rank), .beat_bank_out(beat_bank), .beat_col_out(beat_col),
    .beat_data_out(beat_data), .rd_data_in(rd_data), .bank_open_out(bank_open), .pwr_state0_out(pwr0),
    .pwr_state1_out(pwr1), .in_buf_en_out(buf_en));
  // Open-drain line with pull-up
  assign sda_line = sda_drv & ~(sda_oe & ~sda_o);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task check(input [63:0] seen, input [63:0] exp, input [8*12-1:0] what);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("mismatch at %0t: %0s seen %h expected %h", $time, what, seen, exp);
      end
    end
  endtask
  // Strobe is readable one falling edge after issue
  task run(input [2:0] c, input [1:0] s, input [1:0] k, input [1:0] b, input [12:0] a);
    begin
      u_sdrpi_host.issue(c, s, k, b, a);
      @(negedge clk_in);
    end
  endtask
  task wrap_up;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_banks;
    begin
      check(pwr0, 5'h01, "reset state");
      check(sda_oe, 1'b0, "sda idle");
      run(`SDRPI_CMD_MRS, 2'h2, 2'h3, 2'h0, 13'h0002);
      check(cmd_code, `SDRPI_CMD_MRS, "mrs code");
      run(`SDRPI_CMD_ACT, 2'h2, 2'h3, 2'h2, 13'h0123);
      check(mode_op, 13'h0002, "op code");
      check(cmd_bank, 2'h2, "act bank");
      run(`SDRPI_CMD_ACT, 2'h2, 2'h3, 2'h1, 13'h1fff);
      check(cmd_addr, 13'h1fff, "row");
      run(`SDRPI_CMD_ACT, 2'h1, 2'h3, 2'h3, 13'h0000);
      check(cmd_rank, 1'b1, "rank");
      @(negedge clk_in);
      check(bank_open, 8'h86, "opened");
      run(`SDRPI_CMD_PRE, 2'h2, 2'h3, 2'h2, 13'h0000);
      run(`SDRPI_CMD_PRE, 2'h1, 2'h3, 2'h0, 13'h0400);
      run(`SDRPI_CMD_ACT, 2'h3, 2'h3, 2'h0, 13'h0000);
      check(cmd_stb, 1'b0, "deselected");
      check(bank_open, 8'h02, "closed");
      $display("test banks done");
    end
  endtask
  task t_write;
    begin
      run(`SDRPI_CMD_ACT, 2'h2, 2'h3, 2'h0, 13'h0077);
      u_sdrpi_host.lanes(8'h01, {8{8'ha0}});
      u_sdrpi_host.issue(`SDRPI_CMD_WR, 2'h2, 2'h3, 2'h0, 13'h0405);
      u_sdrpi_host.lanes(8'h04, {8{8'ha1}});
      for (i = 0; i < 4; i = i + 1) begin
        @(negedge clk_in);
        u_sdrpi_host.lanes(8'h01 << (2 * i + 4), {8{8'ha2 + i[7:0]}});
        check(beat_wr, 8'hff ^ (8'h01 << (2 * i)), "lanes");
        check(beat_col, 10'h005 + i, "column");
        check(beat_data, {8{8'ha0 + i[7:0]}}, "write data");
      end
      repeat (4) @(negedge clk_in);
      check(bank_open, 8'h02, "auto close");
      $display("test write done");
    end
  endtask
  task t_read;
    begin
      run(`SDRPI_CMD_ACT, 2'h2, 2'h3, 2'h3, 13'h0100);
      rd_data = 64'h0123456789abcdef;
      u_sdrpi_host.lanes(8'h10, 64'h0);
      u_sdrpi_host.issue(`SDRPI_CMD_RD, 2'h2, 2'h3, 2'h3, 13'h0010);
      n = 0;
      prev = 1'b0;
      for (i = 0; i < 12; i = i + 1) begin
        @(negedge clk_in);
        if (prev) check(oe, 8'hef, "lane drive");
        if (prev) check(data_out, 64'h0123456789abcdef, "read data");
        prev = (beat_rd === 1'b1);
        n = n + prev;
        if (i == 0) u_sdrpi_host.clk_en(2'h0);
        if (i == 3) check(pwr0, 5'h02, "suspend");
        if (i == 3) check(pwr1, 5'h04, "idle pd");
        if (i == 2) u_sdrpi_host.clk_en(2'h3);
      end
      check(n, 4, "beat count");
      $display("test read done");
    end
  endtask
  task t_power;
    begin
      u_sdrpi_host.issue(`SDRPI_CMD_NOP, 2'h3, 2'h2, 2'h0, 13'h0000);
      // Entry one edge after capture, state output one more
      repeat (2) @(negedge clk_in);
      check(pwr0, 5'h08, "active pd");
      check(buf_en, 2'h2, "buffers off");
      run(`SDRPI_CMD_ACT, 2'h2, 2'h2, 2'h0, 13'h0000);
      check(cmd_stb, 1'b0, "pd command");
      u_sdrpi_host.issue(`SDRPI_CMD_NOP, 2'h3, 2'h3, 2'h0, 13'h0000);
      @(negedge clk_in);
      check(pwr0, 5'h01, "pd exit");
      run(`SDRPI_CMD_PRE, 2'h2, 2'h3, 2'h0, 13'h0400);
      u_sdrpi_host.issue(`SDRPI_CMD_NOP, 2'h3, 2'h2, 2'h0, 13'h0000);
      repeat (2) @(negedge clk_in);
      check(pwr0, 5'h04, "idle pd");
      check(bank_open, 8'h00, "all closed");
      u_sdrpi_host.issue(`SDRPI_CMD_NOP, 2'h3, 2'h3, 2'h0, 13'h0000);
      u_sdrpi_host.issue(`SDRPI_CMD_REF, 2'h2, 2'h2, 2'h0, 13'h0000);
      repeat (2) @(negedge clk_in);
      check(pwr0, 5'h10, "self refresh");
      check(pwr1, 5'h01, "rank1 runs");
      u_sdrpi_host.issue(`SDRPI_CMD_NOP, 2'h3, 2'h3, 2'h0, 13'h0000);
      @(negedge clk_in);
      check(pwr0, 5'h01, "sref exit");
      $display("test power done");
    end
  endtask
  // Address byte to the presence-detect slave, data moves while clock is low except at start and stop
  task t_spd;
    begin
      spd_byte = {`SDRPI_SPD_DEV, 1'b0};
      sda_drv = 1'b0;
      repeat (10) @(negedge clk_in);
      scl = 1'b0;
      for (i = 7; i >= 0; i = i - 1) begin
        sda_drv = spd_byte[i];
        repeat (10) @(negedge clk_in);
        scl = 1'b1;
        repeat (10) @(negedge clk_in);
        scl = 1'b0;
      end
      sda_drv = 1'b1;
      repeat (10) @(negedge clk_in);
      check(sda_oe, 1'b1, "spd ack");
      check(sda_line, 1'b0, "sda low");
      scl = 1'b1;
      repeat (10) @(negedge clk_in);
      scl = 1'b0;
      sda_drv = 1'b0;
      repeat (10) @(negedge clk_in);
      check(sda_oe, 1'b0, "spd release");
      scl = 1'b1;
      repeat (10) @(negedge clk_in);
      sda_drv = 1'b1;
      repeat (10) @(negedge clk_in);
      $display("test spd done");
    end
  endtask
  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Tests need about three hundred twenty cycles, about six times that is a hang
  initial begin
    #20000;
    err_total = err_total + 1;
    wrap_up;
  end
  initial begin
    rst_n_in = 1'b0;
    rd_data = 64'h0;
    scl = 1'b1;
    sda_drv = 1'b1;
    err_total = 0;
    comparisons = 0;
    repeat (20) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_banks;
    t_write;
    t_read;
    t_power;
    t_spd;
    wrap_up;
  end
endmodule // tb_sdrpi_pin_if
